//--- mba_defs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef MBA_DEFS_SVH
`define MBA_DEFS_SVH

// Register offsets
`define MBA_OFS_BIAS 8'h19
`define MBA_OFS_LEVEL 8'h1a
`define MBA_OFS_MAXG 8'h1b
`define MBA_OFS_NOISE 8'h1c

// Reset values
`define MBA_RST_BIAS 8'h00
`define MBA_RST_LEVEL 8'h00
`define MBA_RST_MAXG 8'hfe
`define MBA_RST_NOISE 8'h00

// Field positions
`define MBA_BIAS_LVL 7:6
`define MBA_DMIC_SEL 5:4
`define MBA_BIAS_WR 7:4
`define MBA_AGC_EN 7
`define MBA_TARGET 6:4
`define MBA_ATTACK 3:2
`define MBA_DECAY 1:0
`define MBA_MAXG 7:1
`define MBA_HYST 7:6
`define MBA_THRESH 5:1
`define MBA_CLIP 0

// Field codes
`define MBA_DMIC_RESVD 2'h3
`define MBA_HYST_OFF 2'h3
`define MBA_MAXG_LIMIT 7'h76
`define MBA_MAXG_SAT 7'h77
`define MBA_THRESH_BASE 7'h1c

// Timing: one millisecond time base at a 10 MHz clock
`define MBA_TICK_MS 1
`define MBA_CLK_KHZ 10000

`endif

//--- mba_pkg.sv
// Types shared by the record-path configuration block.
package mba_pkg;

    // Bias output level, one-hot
    typedef enum logic [3:0] {
        MBA_BIAS_OFF = 4'b0001,
        MBA_BIAS_2V0 = 4'b0010,
        MBA_BIAS_2V5 = 4'b0100,
        MBA_BIAS_SUPPLY = 4'b1000
    } mba_bias_t;

    // Interval timer state
    typedef enum logic [1:0] {
        MBA_TMR_IDLE = 2'b01,
        MBA_TMR_RUN = 2'b10
    } mba_tmr_state_t;

endpackage : mba_pkg

//--- mba_interval_timer.sv
// Millisecond interval timer giving one step pulse per programmed period, or per halved period at double rate.
`timescale 1ns/100ps
module mba_interval_timer
    import mba_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // Control
    input wire logic tick_i,
    input wire logic run_i,
    input wire logic double_rate_audio_i,
    input wire logic [8:0] period_ms_i,
    // Result
    output logic step_o
);

    mba_tmr_state_t state_q;
    logic [8:0] count_q;
    logic [8:0] limit;

    // Double rate halves the period count on the same time base, so periods halve
    assign limit = double_rate_audio_i ? {1'b0, period_ms_i[8:1]} : period_ms_i;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= MBA_TMR_IDLE;
            count_q <= 9'h000;
            step_o <= 1'b0;
        end else begin
            step_o <= 1'b0;
            case (state_q)
                MBA_TMR_IDLE: begin
                    count_q <= 9'h000;
                    if (run_i) begin
                        state_q <= MBA_TMR_RUN;
                    end
                end
                MBA_TMR_RUN: begin
                    if (!run_i) begin
                        state_q <= MBA_TMR_IDLE;
                    end else if (tick_i) begin
                        // Period change takes effect at the next wrap or earlier
                        if (count_q + 9'h001 >= limit) begin
                            count_q <= 9'h000;
                            step_o <= 1'b1;
                        end else begin
                            count_q <= count_q + 9'h001;
                        end
                    end
                end
                default: begin
                    state_q <= MBA_TMR_IDLE;
                end
            endcase
        end
    end

endmodule // mba_interval_timer

//--- mba_config_regs.sv
// Mic bias and left gain-control configuration registers with field decode.
`timescale 1ns/100ps
`include "mba_defs.svh"
module mba_config_regs
    import mba_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `MBA_TICK_MS * `MBA_CLK_KHZ
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic reg_hit_o,
    // Mode inputs
    input wire logic dmic_enable_i,
    input wire logic double_rate_audio_i,
    // Bias control
    output mba_bias_t mic_bias_output_o,
    output logic left_dmic_o,
    output logic right_dmic_o,
    // Left gain-control settings
    output logic agc_enable_o,
    output logic [7:0] target_atten_tenth_db_o,
    output logic [4:0] attack_ms_o,
    output logic [8:0] decay_ms_o,
    output logic attack_step_o,
    output logic decay_step_o,
    output logic [6:0] max_gain_half_db_o,
    output logic hyst_enable_o,
    output logic [1:0] hyst_db_o,
    output logic noise_detect_en_o,
    output logic [6:0] noise_thresh_db_o,
    output logic clip_step_en_o
);

    // Register storage
    logic [3:0] bias_q;
    logic [7:0] level_q;
    logic [7:0] maxg_q;
    logic [7:0] noise_q;

    // Time base
    logic [13:0] tick_cnt_q;
    logic tick_q;

    // Decoded fields
    logic [1:0] bias_lvl;
    logic [1:0] dmic_sel;
    logic [6:0] maxg_code;
    logic [4:0] thresh_code;
    logic [8:0] attack_period;

    // Address decode, shared by the write and read paths
    function automatic logic [3:0] addr_decode(input logic [7:0] addr);
        logic [3:0] hit;
        hit = 4'h0;
        case (addr)
            `MBA_OFS_BIAS: hit = 4'b0001;
            `MBA_OFS_LEVEL: hit = 4'b0010;
            `MBA_OFS_MAXG: hit = 4'b0100;
            `MBA_OFS_NOISE: hit = 4'b1000;
            default: hit = 4'h0;
        endcase
        return hit;
    endfunction

    // Attack code to milliseconds
    function automatic logic [4:0] attack_ms(input logic [1:0] code);
        logic [4:0] ms;
        ms = 5'h08;
        case (code)
            2'h0: ms = 5'h08;
            2'h1: ms = 5'h0b;
            2'h2: ms = 5'h10;
            2'h3: ms = 5'h14;
            default: ms = 5'h08;
        endcase
        return ms;
    endfunction

    // Decay code to milliseconds
    function automatic logic [8:0] decay_ms(input logic [1:0] code);
        logic [8:0] ms;
        ms = 9'h064;
        case (code)
            2'h0: ms = 9'h064;
            2'h1: ms = 9'h0c8;
            2'h2: ms = 9'h190;
            2'h3: ms = 9'h1f4;
            default: ms = 9'h064;
        endcase
        return ms;
    endfunction

    // Target code to attenuation in tenths of a dB
    function automatic logic [7:0] target_tenths(input logic [2:0] code);
        logic [7:0] t;
        t = 8'h37;
        case (code)
            3'h0: t = 8'h37;
            3'h1: t = 8'h50;
            3'h2: t = 8'h64;
            3'h3: t = 8'h78;
            3'h4: t = 8'h8c;
            3'h5: t = 8'haa;
            3'h6: t = 8'hc8;
            3'h7: t = 8'hf0;
            default: t = 8'h37;
        endcase
        return t;
    endfunction

    logic [3:0] wr_hit;
    logic [3:0] rd_hit;

    assign wr_hit = reg_wr_i ? addr_decode(reg_addr_i) : 4'h0;
    assign rd_hit = addr_decode(reg_addr_i);
    assign reg_hit_o = |rd_hit;

    // Bias register; only the upper nibble holds state
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bias_q <= 4'(`MBA_RST_BIAS >> 4);
        end else if (wr_hit[0]) begin
            bias_q[3:2] <= reg_wdata_i[`MBA_BIAS_LVL];
            // Reserved routing code is dropped so the routing stays defined
            if (reg_wdata_i[`MBA_DMIC_SEL] != `MBA_DMIC_RESVD) begin
                bias_q[1:0] <= reg_wdata_i[`MBA_DMIC_SEL];
            end
        end
    end

    // Gain-control register A
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            level_q <= `MBA_RST_LEVEL;
        end else if (wr_hit[1]) begin
            level_q <= reg_wdata_i;
        end
    end

    // Gain-control register B; bit 0 is kept as written
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            maxg_q <= `MBA_RST_MAXG;
        end else if (wr_hit[2]) begin
            maxg_q <= reg_wdata_i;
        end
    end

    // Gain-control register C
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            noise_q <= `MBA_RST_NOISE;
        end else if (wr_hit[3]) begin
            noise_q <= reg_wdata_i;
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                case (rd_hit)
                    // Reserved low bits read as zero
                    4'b0001: reg_rdata_o <= {bias_q, 4'h0};
                    4'b0010: reg_rdata_o <= level_q;
                    4'b0100: reg_rdata_o <= maxg_q;
                    4'b1000: reg_rdata_o <= noise_q;
                    default: reg_rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // Bias level decode
    assign bias_lvl = bias_q[3:2];

    always_comb begin
        case (bias_lvl)
            2'h0: mic_bias_output_o = MBA_BIAS_OFF;
            2'h1: mic_bias_output_o = MBA_BIAS_2V0;
            2'h2: mic_bias_output_o = MBA_BIAS_2V5;
            2'h3: mic_bias_output_o = MBA_BIAS_SUPPLY;
            default: mic_bias_output_o = MBA_BIAS_OFF;
        endcase
    end

    // Digital mic routing, only while digital mics are enabled
    assign dmic_sel = bias_q[1:0];

    always_comb begin
        left_dmic_o = 1'b0;
        right_dmic_o = 1'b0;
        if (dmic_enable_i) begin
            case (dmic_sel)
                2'h0: begin
                    left_dmic_o = 1'b1;
                    right_dmic_o = 1'b1;
                end
                2'h1: left_dmic_o = 1'b1;
                2'h2: right_dmic_o = 1'b1;
                default: begin
                    left_dmic_o = 1'b0;
                    right_dmic_o = 1'b0;
                end
            endcase
        end
    end

    // Level and timing decode
    assign agc_enable_o = level_q[`MBA_AGC_EN];
    assign target_atten_tenth_db_o = target_tenths(level_q[`MBA_TARGET]);
    assign attack_ms_o = attack_ms(level_q[`MBA_ATTACK]);
    assign decay_ms_o = decay_ms(level_q[`MBA_DECAY]);
    assign attack_period = {4'h0, attack_ms_o};

    // Maximum gain, clamped above the last linear code
    assign maxg_code = maxg_q[`MBA_MAXG];
    assign max_gain_half_db_o = (maxg_code > `MBA_MAXG_LIMIT) ? `MBA_MAXG_SAT
        : maxg_code;

    // Noise gate
    assign hyst_enable_o = noise_q[`MBA_HYST] != `MBA_HYST_OFF;
    assign hyst_db_o = hyst_enable_o ? noise_q[7:6] + 2'h1 : 2'h0;
    assign thresh_code = noise_q[`MBA_THRESH];
    assign noise_detect_en_o = thresh_code != 5'h00;
    // Threshold magnitude is 28 + 2 * code dB
    assign noise_thresh_db_o = noise_detect_en_o
        ? `MBA_THRESH_BASE + {1'b0, thresh_code, 1'b0} : 7'h00;
    assign clip_step_en_o = noise_q[`MBA_CLIP];

    // Millisecond enable pulse from the system clock
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_cnt_q <= 14'h0000;
            tick_q <= 1'b0;
        end else if (tick_cnt_q >= 14'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= 14'h0000;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 14'h0001;
            tick_q <= 1'b0;
        end
    end

    // Step timers pace the gain loop; they idle while gain control is off
    mba_interval_timer u_attack_timer (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .tick_i(tick_q),
        .run_i(agc_enable_o),
        .double_rate_audio_i(double_rate_audio_i),
        .period_ms_i(attack_period),
        .step_o(attack_step_o)
    );

    mba_interval_timer u_decay_timer (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .tick_i(tick_q),
        .run_i(agc_enable_o),
        .double_rate_audio_i(double_rate_audio_i),
        .period_ms_i(decay_ms_o),
        .step_o(decay_step_o)
    );

endmodule // mba_config_regs

//--- mba_cfg_monitor.sv
// Concurrent checks on the configuration register block ports.
`timescale 1ns/100ps
module mba_cfg_monitor
    import mba_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic reg_hit_o,
    // Settings
    input wire logic dmic_enable_i,
    input wire mba_bias_t mic_bias_output_o,
    input wire logic left_dmic_o,
    input wire logic right_dmic_o,
    input wire logic agc_enable_o,
    input wire logic attack_step_o,
    input wire logic [6:0] max_gain_half_db_o,
    input wire logic hyst_enable_o,
    input wire logic [6:0] noise_thresh_db_o,
    input wire logic clip_step_en_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // Field slices, so $past sees plain signals
    wire logic [1:0] wb = reg_wdata_i[7:6];
    wire logic [6:0] wg = reg_wdata_i[7:1];
    wire logic [4:0] wt = reg_wdata_i[5:1];
    wire logic wa = reg_wr_i && reg_addr_i == 8'h1a;
    wire logic wc = reg_wr_i && reg_addr_i == 8'h1c;

    a_rvalid_follows_read: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("no read valid after read");
    a_unmapped_reads_zero: assert property (reg_rd_i && !reg_hit_o |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_bias_level_decode: assert property (reg_wr_i && reg_addr_i == 8'h19
        |=> mic_bias_output_o == (4'h1 << $past(wb)))
        else $error("bias level wrong");
    a_agc_enable_write: assert property (wa |=> agc_enable_o == $past(reg_wdata_i[7]))
        else $error("gain control enable wrong");
    a_max_gain_clamp: assert property (reg_wr_i && reg_addr_i == 8'h1b
        |=> max_gain_half_db_o == ($past(wg) > 7'h76 ? 7'h77 : $past(wg)))
        else $error("max gain wrong");
    a_hyst_code_decode: assert property (wc |=> hyst_enable_o == ($past(wb) != 2'h3))
        else $error("hysteresis enable wrong");
    a_thresh_code_decode: assert property (wc |=> noise_thresh_db_o ==
        ($past(wt) == 5'h0 ? 7'h0 : {1'b0, $past(wt), 1'b0} + 7'd28))
        else $error("noise threshold wrong");
    a_clip_enable_write: assert property (wc |=> clip_step_en_o == $past(reg_wdata_i[0]))
        else $error("clip stepping wrong");
    a_dmic_needs_enable: assert property (!dmic_enable_i |-> !left_dmic_o && !right_dmic_o)
        else $error("digital mic routed while disabled");
    a_step_needs_agc: assert property (!agc_enable_o && !$past(agc_enable_o) |-> !attack_step_o)
        else $error("attack step while gain control off");

    c_read: cover property (reg_rd_i ##1 reg_rvalid_o);
    c_step: cover property (attack_step_o);
    c_sat: cover property (max_gain_half_db_o == 7'h77 && reg_wr_i);
endmodule // mba_cfg_monitor

bind mba_config_regs mba_cfg_monitor mba_cfg_monitor_inst (.clock_i(clock_i),
    .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .reg_hit_o(reg_hit_o), .dmic_enable_i(dmic_enable_i), .mic_bias_output_o(mic_bias_output_o),
    .left_dmic_o(left_dmic_o), .right_dmic_o(right_dmic_o), .agc_enable_o(agc_enable_o),
    .attack_step_o(attack_step_o), .max_gain_half_db_o(max_gain_half_db_o),
    .hyst_enable_o(hyst_enable_o), .noise_thresh_db_o(noise_thresh_db_o),
    .clip_step_en_o(clip_step_en_o));

//--- tb.sv
// Self-checking bench for the configuration register block.
`timescale 1ns/100ps
module tb;
    import mba_pkg::*;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic dmic_enable_i = 1'b1;
    logic double_rate_audio_i = 1'b0;
    logic [7:0] reg_rdata_o, tgt_o;
    logic reg_rvalid_o, reg_hit_o, l_o, r_o, agc_o, as_o, ds_o, he_o, nd_o, clip_o;
    mba_bias_t bias_o;
    logic [4:0] atk_o;
    logic [8:0] dcy_o;
    logic [6:0] mg_o, th_o;
    logic [1:0] hd_o;
    int fails = 0;
    int n_tests = 0;
    int n;
    int m;
    logic [7:0] rv;
    // Address, write data, read-back
    logic [23:0] rows [11] = '{24'h19d5d0, 24'h196f60, 24'h1affff, 24'h1a5a5a, 24'h1beded,
        24'h1b0000, 24'h1cc3c3, 24'h1c3e3e, 24'h40aa00, 24'h1d5500, 24'h187700};
    logic [7:0] rst_v [4] = '{8'h00, 8'h00, 8'hfe, 8'h00};
    logic [15:0] tgt [8] = '{16'd55, 16'd80, 16'd100, 16'd120, 16'd140, 16'd170, 16'd200, 16'd240};
    logic [15:0] atk [4] = '{16'd8, 16'd11, 16'd16, 16'd20};
    logic [15:0] dcy [4] = '{16'd100, 16'd200, 16'd400, 16'd500};

    // Short tick of four clocks per millisecond keeps the timer periods between 16 and 2000 clocks
    mba_config_regs #(.TICK_CYCLES(4)) mba_config_regs_inst (.clock_i(clock_i),
        .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .reg_hit_o(reg_hit_o), .dmic_enable_i(dmic_enable_i),
        .double_rate_audio_i(double_rate_audio_i), .mic_bias_output_o(bias_o),
        .left_dmic_o(l_o), .right_dmic_o(r_o), .agc_enable_o(agc_o),
        .target_atten_tenth_db_o(tgt_o), .attack_ms_o(atk_o), .decay_ms_o(dcy_o),
        .attack_step_o(as_o), .decay_step_o(ds_o), .max_gain_half_db_o(mg_o),
        .hyst_enable_o(he_o), .hyst_db_o(hd_o), .noise_detect_en_o(nd_o),
        .noise_thresh_db_o(th_o), .clip_step_en_o(clip_o));

    always #50 clock_i = ~clock_i;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clock_i);
        reg_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(negedge clock_i);
        reg_rd_i = 1'b0;
        chk({15'h0, reg_rvalid_o}, 16'h1);
        d = reg_rdata_o;
    endtask

    task automatic cnt(input int cyc, output int k, output int j);
        k = 0;
        j = 0;
        repeat (cyc) begin
            @(negedge clock_i);
            if (as_o === 1'b1) k++;
            if (ds_o === 1'b1) j++;
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons=%0d mismatches=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        #1000000;
        fails++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(negedge clock_i);
        resetn_i = 1'b1;
        chk({12'h0, bias_o}, 16'h1);
        chk({9'h0, mg_o}, 16'h77);
        for (int i = 0; i < 4; i++) begin
            rd(8'h19 + 8'(i), rv);
            chk({8'h0, rv}, {8'h0, rst_v[i]});
        end
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rv);
            chk({8'h0, rv}, {8'h0, rows[i][7:0]});
            chk({15'h0, reg_hit_o}, {15'h0, (rows[i][23:16] inside {[8'h19:8'h1c]})});
        end
        $display("test readback done");
        for (int i = 0; i < 8; i++) begin
            wr(8'h1a, {1'b0, i[2:0], i[1:0], i[1:0]});
            chk({8'h0, tgt_o}, tgt[i]);
            chk({11'h0, atk_o}, atk[i % 4]);
            chk({7'h0, dcy_o}, dcy[i % 4]);
        end
        for (int i = 0; i < 4; i++) begin
            wr(8'h19, {i[1:0], 6'h0});
            chk({12'h0, bias_o}, 16'h1 << i);
            wr(8'h1c, {i[1:0], 6'h0});
            chk({13'h0, he_o, hd_o}, (i == 3) ? 16'h0 : 16'(4 + i + 1));
            chk({15'h0, clip_o}, 16'h0);
        end
        for (int i = 0; i < 3; i++) begin
            wr(8'h19, {2'b01, i[1:0], 4'h0});
            chk({14'h0, l_o, r_o}, {14'h0, i != 2, i != 1});
        end
        @(negedge clock_i);
        dmic_enable_i = 1'b0;
        #1;
        chk({14'h0, l_o, r_o}, 16'h0);
        dmic_enable_i = 1'b1;
        wr(8'h19, 8'hf0);
        rd(8'h19, rv);
        chk({8'h0, rv}, 16'he0);
        $display("test decode done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h1b, {7'h76 + 7'(i), 1'b0});
            chk({9'h0, mg_o}, (i == 0) ? 16'h76 : 16'h77);
        end
        for (int i = 0; i < 3; i++) begin
            n = (i == 0) ? 0 : (i == 1) ? 1 : 31;
            wr(8'h1c, {2'b11, n[4:0], 1'b1});
            chk({15'h0, nd_o}, {15'h0, n != 0});
            chk({9'h0, th_o}, (n == 0) ? 16'h0 : 16'(28 + 2 * n));
            chk({15'h0, clip_o}, 16'h1);
        end
        // Write and read in one cycle: read sees the old value
        @(negedge clock_i);
        reg_wr_i = 1'b1;
        reg_rd_i = 1'b1;
        reg_addr_i = 8'h1a;
        reg_wdata_i = 8'h11;
        @(negedge clock_i);
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        chk({8'h0, reg_rdata_o}, 16'h7f);
        rd(8'h1a, rv);
        chk({8'h0, rv}, 16'h11);
        $display("test collision done");
        wr(8'h1a, 8'h80);
        chk({15'h0, agc_o}, 16'h1);
        cnt(320, n, m);
        chk({15'h0, (n inside {[9:11]})}, 16'h1);
        chk(16'(m), 16'h0);
        double_rate_audio_i = 1'b1;
        cnt(320, n, m);
        chk({15'h0, (n inside {[19:21]})}, 16'h1);
        chk({15'h0, (m inside {[2:3]})}, 16'h1);
        wr(8'h1a, 8'h00);
        cnt(100, n, m);
        chk(16'(n), 16'h0);
        chk(16'(m), 16'h0);
        double_rate_audio_i = 1'b0;
        $display("test timer done");
        @(negedge clock_i);
        resetn_i = 1'b0;
        repeat (2) @(negedge clock_i);
        resetn_i = 1'b1;
        rd(8'h1b, rv);
        chk({8'h0, rv}, 16'hfe);
        rd(8'h1c, rv);
        chk({8'h0, rv}, 16'h00);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule // tb
